/* File: logic/fss_pkg.sv */
// Purpose: Shared constants and types of the frame schedule sequencer.
// Assumes: 40 MHz system clock, one frame timebase.
// Notes: Frame time is kept in ticks; one tick is a fixed number of clocks.
`default_nettype none
package fss_pkg;
    // Timing
    localparam int CLOCK_KHZ = 40000;
    localparam int FRAME_US = 1000;
    localparam int TICK_NS = 1000;
    localparam int CYCLES_PER_TICK = (TICK_NS * CLOCK_KHZ) / 1000000;
    localparam int TICKS_PER_FRAME = (FRAME_US * 1000) / TICK_NS;
    localparam int TICK_CNT_W = 12;
    // Schedule geometry
    localparam int MAX_ENTRIES = 64;
    localparam int IDX_W = 6;
    localparam int TIME_W = 10;
    localparam int WORD_W = 38;
    localparam int STROBE_W = 30;
    localparam int MTX_OUTPUTS = 4;
    localparam int MTX_SEL_W = 2;
    // Reset values
    localparam logic ONLINE_RST = 1'b0;
    localparam logic VERIFY_ONLINE_RST = 1'b0;

    typedef logic [TIME_W-1:0] fss_time_t;
    typedef logic [IDX_W-1:0] fss_idx_t;
    typedef logic [WORD_W-1:0] fss_word_t;
    typedef logic [MTX_OUTPUTS-1:0][MTX_SEL_W-1:0] fss_route_t;

    typedef struct packed {
        fss_time_t swTime;
        fss_word_t word;
    } fss_entry_t;

    typedef struct packed {
        fss_idx_t idx;
        fss_entry_t entry;
    } fss_load_t;
endpackage
`default_nettype wire

/* File: logic/fss_timebase.sv */
// Purpose: Tick divider and running frame-time count.
// Assumes: Single clock; ticks are one-cycle enables.
// Notes: A frame start pulse is also given right after reset release.
`default_nettype none
module fss_timebase
    import fss_pkg::*;
#(
    parameter int CYCLES_PER_TICK = fss_pkg::CYCLES_PER_TICK,
    parameter int TICKS_PER_FRAME = fss_pkg::TICKS_PER_FRAME
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Timebase
    output logic frameStart,
    output logic timeStep,
    output fss_pkg::fss_time_t frameTime
);
    localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(CYCLES_PER_TICK - 1);
    localparam fss_time_t FRAME_LAST = TIME_W'(TICKS_PER_FRAME - 1);

    logic [TICK_CNT_W-1:0] divCnt_reg;
    logic started_reg;
    logic tick;

    assign tick = started_reg && (divCnt_reg == TICK_LAST);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            divCnt_reg <= '0;
        end else if (!started_reg || tick) begin
            divCnt_reg <= '0;
        end else begin
            divCnt_reg <= divCnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            started_reg <= 1'b0;
        end else begin
            started_reg <= 1'b1;
        end
    end

    // Frame time counts ticks and wraps at the frame length
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            frameTime <= '0;
            frameStart <= 1'b0;
            timeStep <= 1'b0;
        end else begin
            frameStart <= !started_reg || (tick && frameTime == FRAME_LAST);
            timeStep <= tick && frameTime != FRAME_LAST;
            if (tick) begin
                frameTime <= (frameTime == FRAME_LAST) ? '0 : frameTime + 1'b1; // RULE_10
            end
        end
    end
endmodule
`default_nettype wire

/* File: logic/fss_bank_mem.sv */
// Purpose: Two identical schedule banks in flip-flops.
// Assumes: Write and play never target the same bank in normal use.
// Notes: Reads are combinational; an index past the depth reads as zero.
`default_nettype none
module fss_bank_mem
    import fss_pkg::*;
#(
    parameter int NUM_ENTRIES = MAX_ENTRIES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Write port
    input wire logic wrEn,
    input wire logic wrBank,
    input wire fss_pkg::fss_load_t wrLoad,
    // Playback read
    input wire logic playBank,
    input wire fss_pkg::fss_idx_t playIdx,
    output fss_pkg::fss_entry_t playEntry,
    // Verify read
    input wire logic vfyBank,
    input wire fss_pkg::fss_idx_t vfyIdx,
    output fss_pkg::fss_entry_t vfyEntry
);
    fss_entry_t mem [2][NUM_ENTRIES];

    function automatic fss_entry_t readEntry(input logic bank, input fss_idx_t idx);
        fss_entry_t e;
        e = '0;
        if (int'(idx) < NUM_ENTRIES) begin
            e = mem[bank][idx];
        end
        return e;
    endfunction

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int b = 0; b < 2; b++) begin
                for (int i = 0; i < NUM_ENTRIES; i++) begin
                    mem[b][i] <= '0;
                end
            end
        end else if (wrEn && int'(wrLoad.idx) < NUM_ENTRIES) begin
            mem[wrBank][wrLoad.idx] <= wrLoad.entry; // RULE_05
        end
    end

    assign playEntry = readEntry(playBank, playIdx);
    assign vfyEntry = readEntry(vfyBank, vfyIdx);
endmodule
`default_nettype wire

/* File: logic/fss_seq.sv */
// Purpose: Frame-scheduled configuration sequencer with paired banks.
// Assumes: Loader and swap commands come from logic on the same clock.
// Notes: One control word drives both beam and switch-matrix outputs.
//
// Overview of operation
// RULE_01 - The stored list of control words replays from its start every frame.
// RULE_02 - Beam use allows up to 64 positions per 1 ms frame, each with its own duration.
// RULE_03 - Switch-matrix use allows up to 64 bursts per 1 ms frame, each with its own duration.
// RULE_04 - Each control word picks one matrix input for every output independently.
// RULE_05 - Two identical banks exist and exactly one, the on-line bank, feeds the outputs.
// RULE_06 - Loader writes go only to the off-line bank and never disturb playback; a write in a swapping boundary cycle lands in the bank going on-line.
// RULE_07 - The loader supplies switch-matrix words relayed from the orderwire channel.
// RULE_08 - A swap exchanges the bank roles exactly at the next frame start.
// RULE_09 - Mode control holds on-line, off-line and verify-bank state.
// RULE_10 - Each entry holds a switchover time, compared against a running frame time.
// RULE_11 - When frame time equals the entry's switchover time, the next word is read out.
// RULE_12 - Beam outputs are a 38 bit position word and 30 element strobes.
// RULE_13 - Strobes are the XOR of old and new position, set only where bits change.
// RULE_14 - The controller loads the off-line bank before it issues the swap.
// RULE_15 - Each frame start clears frame time and points at entry 0 of the on-line bank.
// RULE_16 - Swap commands wait for the boundary, and several in a frame give one swap.
`default_nettype none
module fss_seq
    import fss_pkg::*;
#(
    parameter int NUM_ENTRIES = MAX_ENTRIES,
    parameter int CYCLES_PER_TICK = fss_pkg::CYCLES_PER_TICK,
    parameter int TICKS_PER_FRAME = fss_pkg::TICKS_PER_FRAME
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Loader
    input wire logic loadValid,
    input wire fss_pkg::fss_load_t loadData,
    input wire logic swapCmd,
    // Verification read-back
    input wire logic verifySelWr,
    input wire logic verifySelOnline,
    input wire fss_pkg::fss_idx_t verifyIdx,
    output fss_pkg::fss_entry_t verifyData,
    // Mode status
    output logic onlineBank,
    output logic offlineBank,
    output logic verifyBank,
    output logic swapPending,
    // Schedule status
    output logic frameMark,
    output fss_pkg::fss_idx_t entryIdx,
    // Beam steering network
    output fss_pkg::fss_word_t beamPosition,
    output logic [STROBE_W-1:0] elementStrobe,
    // Switch matrix
    output fss_pkg::fss_route_t routeSelect
);
    localparam fss_idx_t LAST_IDX = IDX_W'(NUM_ENTRIES - 1);

    if (NUM_ENTRIES < 1 || NUM_ENTRIES > MAX_ENTRIES ||
        TICKS_PER_FRAME < 2 || TICKS_PER_FRAME > (1 << TIME_W) ||
        CYCLES_PER_TICK < 1 || CYCLES_PER_TICK > (1 << TICK_CNT_W) ||
        MTX_OUTPUTS * MTX_SEL_W > WORD_W || STROBE_W > WORD_W) begin : g_bad_params
        $error("fss_seq: parameter values out of range");
    end

    // Timebase
    logic frameStart;
    logic timeStep;
    fss_time_t frameTime;

    // Mode control
    logic online_reg;
    logic verifyOnline_reg;
    logic pending_reg;
    logic nextOnline;

    // Playback
    fss_idx_t addr_reg;
    fss_idx_t addr_next;
    fss_time_t curTime_reg;
    fss_word_t word_reg;
    logic advance;
    logic loadEntry;
    logic playBank;
    fss_idx_t playIdx;
    fss_entry_t playEntry;
    fss_entry_t vfyEntry;
    logic vfyBankSel;

    fss_timebase #(
        .CYCLES_PER_TICK(CYCLES_PER_TICK),
        .TICKS_PER_FRAME(TICKS_PER_FRAME)
    ) u_timebase (
        .clock(clock),
        .reset_n(reset_n),
        .frameStart(frameStart),
        .timeStep(timeStep),
        .frameTime(frameTime)
    );

    // Bank that is on-line after this cycle's boundary decision
    assign nextOnline = (frameStart && pending_reg) ? ~online_reg : online_reg; // RULE_08

    // Swap is held for the boundary; a command in the boundary cycle counts for the new frame
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pending_reg <= 1'b0;
        end else if (frameStart) begin
            pending_reg <= swapCmd; // RULE_16
        end else begin
            pending_reg <= pending_reg | swapCmd; // RULE_16
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            online_reg <= ONLINE_RST;
        end else begin
            online_reg <= nextOnline; // RULE_08 RULE_09
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            verifyOnline_reg <= VERIFY_ONLINE_RST;
        end else if (verifySelWr) begin
            verifyOnline_reg <= verifySelOnline; // RULE_09
        end
    end

    // Advance once per tick on a time match; the list holds at its last entry
    assign advance = timeStep && (frameTime == curTime_reg) && (addr_reg != LAST_IDX); // RULE_11
    assign loadEntry = frameStart || advance;
    assign addr_next = frameStart ? '0 : addr_reg + 1'b1; // RULE_15
    assign playBank = nextOnline; // RULE_05
    assign playIdx = addr_next;
    assign vfyBankSel = verifyOnline_reg ? online_reg : ~online_reg;

    // Writes always land in the present off-line bank
    fss_bank_mem #(
        .NUM_ENTRIES(NUM_ENTRIES)
    ) u_banks (
        .clock(clock),
        .reset_n(reset_n),
        .wrEn(loadValid),
        .wrBank(~online_reg), // RULE_06
        .wrLoad(loadData),
        .playBank(playBank),
        .playIdx(playIdx),
        .playEntry(playEntry),
        .vfyBank(vfyBankSel),
        .vfyIdx(verifyIdx),
        .vfyEntry(vfyEntry)
    );

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            addr_reg <= '0;
            curTime_reg <= '0;
        end else if (loadEntry) begin
            addr_reg <= addr_next; // RULE_01 RULE_02 RULE_03
            curTime_reg <= playEntry.swTime; // RULE_10
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            word_reg <= '0;
        end else if (loadEntry) begin
            word_reg <= playEntry.word; // RULE_01
        end
    end

    // Only changed elements are strobed, so unchanged switches draw no power
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            elementStrobe <= '0;
        end else if (loadEntry) begin
            elementStrobe <= STROBE_W'(word_reg ^ playEntry.word); // RULE_13
        end else begin
            elementStrobe <= '0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            beamPosition <= '0;
            routeSelect <= '0;
        end else if (loadEntry) begin
            beamPosition <= playEntry.word; // RULE_12
            routeSelect <= fss_route_t'(playEntry.word[MTX_OUTPUTS*MTX_SEL_W-1:0]); // RULE_04
        end
    end

    // Status outputs, registered so they follow the internal state by one cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            onlineBank <= ONLINE_RST;
            offlineBank <= ~ONLINE_RST;
            verifyBank <= ~ONLINE_RST;
            swapPending <= 1'b0;
            frameMark <= 1'b0;
            entryIdx <= '0;
        end else begin
            onlineBank <= online_reg; // RULE_09
            offlineBank <= ~online_reg; // RULE_09
            verifyBank <= vfyBankSel; // RULE_09
            swapPending <= pending_reg;
            frameMark <= frameStart;
            entryIdx <= addr_reg;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            verifyData <= '0;
        end else begin
            verifyData <= vfyEntry;
        end
    end
endmodule
`default_nettype wire

/* File: sim/fss_seq_props.sv */
// Purpose: Port checks of the sequencer.
// Assumes: Short frame parameters in simulation.
// Notes: Frame length uses a counter, not a long delay.
`default_nettype none
module fss_seq_props
    import fss_pkg::*;
#(
    parameter int CYCLES_PER_TICK = 2,
    parameter int TICKS_PER_FRAME = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Observed outputs
    input wire logic onlineBank,
    input wire logic offlineBank,
    input wire logic swapPending,
    input wire logic frameMark,
    input wire fss_pkg::fss_idx_t entryIdx,
    input wire fss_pkg::fss_word_t beamPosition,
    input wire logic [STROBE_W-1:0] elementStrobe,
    input wire fss_pkg::fss_route_t routeSelect
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FRAME_CYC = CYCLES_PER_TICK * TICKS_PER_FRAME;
    logic seen_reg;
    int cnt_reg;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            seen_reg <= 1'b0;
            cnt_reg <= 0;
        end else begin
            seen_reg <= seen_reg | frameMark;
            cnt_reg <= frameMark ? 1 : cnt_reg + 1;
        end
    end
    default clocking @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    bank_pair_a: assert property (offlineBank == !onlineBank)
        else $error("off-line bank is not the other bank");
    // Bank status trails the frame mark by one cycle
    flip_at_frame_a: assert property ($changed(onlineBank) |-> $past(frameMark))
        else $error("bank roles changed inside a frame");
    pending_flip_a: assert property (frameMark && swapPending |=>
        onlineBank != $past(onlineBank)) else $error("pending swap not taken");
    pending_hold_a: assert property (swapPending && !frameMark |=> swapPending)
        else $error("swap pending dropped before boundary");
    strobe_xor_a: assert property (elementStrobe ==
        STROBE_W'(beamPosition ^ $past(beamPosition))) else $error("strobe mismatch");
    route_word_a: assert property (routeSelect == beamPosition[7:0])
        else $error("route select not from word");
    frame_period_a: assert property (seen_reg && (frameMark || cnt_reg == FRAME_CYC) |->
        frameMark && cnt_reg == FRAME_CYC) else $error("frame length wrong");
    frame_restart_a: assert property (frameMark |=> entryIdx == '0)
        else $error("entry index not back at zero");
    idx_step_a: assert property ($changed(entryIdx) |->
        (entryIdx == fss_idx_t'($past(entryIdx) + 1'b1)) || (entryIdx == '0))
        else $error("entry index skipped");
    cover property (frameMark && onlineBank);
    cover property (|elementStrobe);
    cover property (swapPending ##1 !swapPending);
endmodule
bind fss_seq fss_seq_props #(.CYCLES_PER_TICK(CYCLES_PER_TICK),
    .TICKS_PER_FRAME(TICKS_PER_FRAME)) props (.clock, .reset_n, .onlineBank, .offlineBank,
    .swapPending, .frameMark, .entryIdx, .beamPosition, .elementStrobe, .routeSelect);
`default_nettype wire

/* File: sim/fss_loader_model.sv */
// Purpose: Command interface unit feeding the sequencer.
// Assumes: Caller keeps writes off the frame boundary cycle.
// Notes: Idle data shows the inverse of the last word.
`default_nettype none
module fss_loader_model
    import fss_pkg::*;
(
    // Clock
    input wire logic clock,
    // Loader
    output logic loadValid,
    output fss_pkg::fss_load_t loadData,
    output logic swapCmd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        loadValid = 1'b0;
        loadData = '0;
        swapCmd = 1'b0;
    end
    // Off-line writes only; words relayed from the orderwire
    task automatic load(input fss_idx_t i, input fss_time_t t, input fss_word_t w);
        @(posedge clock);
        loadValid <= 1'b1;
        loadData <= {i, t, w};
        @(posedge clock);
        loadValid <= 1'b0;
        loadData <= ~loadData;
    endtask
    // Issued once the new entries are loaded into the off-line bank
    task automatic swap();
        @(posedge clock);
        swapCmd <= 1'b1;
        @(posedge clock);
        swapCmd <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: sim/frame_schedule_sequencer_tb_top.sv */
// Purpose: Self-checking bench of the sequencer.
// Assumes: Frame of 16 ticks of 2 clocks.
// Notes: Off-line bank A starts empty.
`default_nettype none
module frame_schedule_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fss_pkg::*;
    localparam int CPT = 2;
    localparam fss_word_t W0 = 38'h15a5a5c3e4;
    localparam fss_word_t W1 = 38'h2a5a5a3c1b;
    localparam fss_word_t W2 = 38'h3f0000ff27;
    logic clock, reset_n, loadValid, swapCmd, verifySelWr, verifySelOnline;
    logic onlineBank, offlineBank, verifyBank, swapPending, frameMark;
    fss_load_t loadData;
    fss_idx_t verifyIdx, entryIdx;
    fss_entry_t verifyData;
    fss_word_t beamPosition;
    logic [STROBE_W-1:0] elementStrobe;
    fss_route_t routeSelect;
    int errors, num_checks;
    fss_loader_model ldr (.clock, .loadValid, .loadData, .swapCmd);
    fss_seq #(.CYCLES_PER_TICK(CPT), .TICKS_PER_FRAME(16)) dut (.clock, .reset_n,
        .loadValid, .loadData, .swapCmd, .verifySelWr, .verifySelOnline, .verifyIdx,
        .verifyData, .onlineBank, .offlineBank, .verifyBank, .swapPending, .frameMark,
        .entryIdx, .beamPosition, .elementStrobe, .routeSelect);
    initial clock = 1'b0;
    always #12.5 clock = ~clock;
    task automatic summarize();
        if (errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic wait_mark();
        int n;
        n = 0;
        do begin @(posedge clock); #1; n++; end while (frameMark !== 1'b1 && n < 100);
        if (frameMark !== 1'b1) errors++;
    endtask
    task automatic wait_change(output int n);
        fss_word_t prev;
        prev = beamPosition;
        n = 0;
        do begin @(posedge clock); #1; n++; end while (beamPosition === prev && n < 100);
        if (beamPosition === prev) errors++;
    endtask
    task automatic vread(input logic sel, input fss_idx_t i, input logic [47:0] exp);
        @(posedge clock);
        verifySelOnline <= sel;
        verifySelWr <= 1'b1;
        verifyIdx <= i;
        @(posedge clock);
        verifySelWr <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        check("verifyData", verifyData, exp);
        check("verifyBank", verifyBank, sel ? onlineBank : offlineBank);
    endtask
    task automatic test_load();
        wait_mark();
        ldr.load(6'h00, 10'h004, W0);
        ldr.load(6'h01, 10'h009, W1);
        ldr.load(6'h02, 10'h000, W2);
        ldr.load(6'h3f, 10'h007, W0);
        check("beamPosition", beamPosition, '0);
        vread(1'b0, 6'h01, {10'h009, W1});
        vread(1'b0, 6'h3f, {10'h007, W0});
    endtask
    task automatic test_swap();
        wait_mark();
        ldr.swap();
        ldr.swap();
        @(posedge clock);
        #1;
        check("swapPending", swapPending, 1'b1);
        check("onlineBank", onlineBank, 1'b0);
        wait_mark();
        // Status flags follow the internal bank state one cycle after the frame mark
        @(posedge clock);
        #1;
        check("onlineBank", onlineBank, 1'b1);
        check("swapPending", swapPending, 1'b0);
        check("beamPosition", beamPosition, W0);
        wait_mark();
        check("onlineBank", onlineBank, 1'b1);
    endtask
    task automatic test_play();
        int n;
        check("beamPosition", beamPosition, W0);
        wait_change(n);
        check("beamPosition", beamPosition, W1);
        check("elementStrobe", elementStrobe, STROBE_W'(W0 ^ W1));
        check("routeSelect", routeSelect, W1[7:0]);
        wait_change(n);
        check("beamPosition", beamPosition, W2);
        check("entryIdx", entryIdx, 6'h01);
        check("holdCycles", n, (9 - 4) * CPT);
        wait_change(n);
        check("beamPosition", beamPosition, W0);
        check("frameMark", frameMark, 1'b1);
    endtask
    initial begin
        #(25 * 5000);
        errors++;
        summarize();
    end
    initial begin
        errors = 0;
        num_checks = 0;
        reset_n = 1'b0;
        verifySelWr = 1'b0;
        verifySelOnline = 1'b0;
        verifyIdx = '0;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        #1;
        check("offlineBank", offlineBank, 1'b1);
        check("verifyBank", verifyBank, 1'b1);
        test_load();
        test_swap();
        test_play();
        vread(1'b1, 6'h00, {10'h004, W0});
        vread(1'b0, 6'h01, '0);
        summarize();
    end
endmodule
`default_nettype wire
